// ---- include/eeprom_seq_pkg.sv ----
// package: constants and types for the serial eeprom command sequencer
package eeprom_seq_pkg;
  localparam logic [7:0]  OP_READ        = 8'h03;
  localparam logic [7:0]  OP_WRITE_A     = 8'h02;
  localparam logic [7:0]  OP_WRITE_B     = 8'h07;
  localparam logic [7:0]  OP_WRITE_ENABLE_CMD        = 8'h06;
  localparam logic [7:0]  OP_STATUS      = 8'h05;
  localparam logic [7:0]  OP_POLL        = 8'h08;
  localparam logic [7:0]  POLL_BUSY      = 8'hFF;
  localparam logic [7:0]  POLL_IDLE      = 8'h00;
  localparam int          ADDR_BITS      = 18;
  localparam int          CMD_ADDR_BITS  = 24;
  localparam int          PAGE_BITS      = 8;
  localparam int          WORD_BYTES     = 4;
  localparam int          CHECK_BITS     = 6;
  localparam int          STAT_BUSY_POS  = 0;
  localparam int          STAT_WEL_POS   = 1;
  localparam int          STAT_BP0_POS   = 2;
  localparam int          STAT_BP1_POS   = 3;
  localparam logic [1:0]  BP_RESET       = 2'h0;
  localparam logic [17:0] QUARTER_BASE   = 18'h30000;
  localparam logic [17:0] HALF_BASE      = 18'h20000;
  localparam int          CLK_NS         = 8;
  localparam int          WRITE_CYCLE_NS = 10000000;
  localparam int          WRITE_CYCLES   = WRITE_CYCLE_NS / CLK_NS;
  localparam int          FIFO_DEPTH     = 32;

  // one buffered page byte: its low address bits and its data
  typedef struct packed {
    logic [7:0] col;
    logic [7:0] data;
  } page_byte_t;
endpackage

// ---- hdl/page_fifo.sv ----
// module: parameterised valid/ready fifo holding page write bytes
`timescale 1ns/100ps
`default_nettype none
module page_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             flush
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // honest full and empty from the fill count
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH)) && !flush;
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_r];

  // storage array
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge core_clk) begin
    if (!rstn || flush) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ---- hdl/eeprom_seq.sv ----
// module: spi eeprom read, write, status and ecc command sequencer
`timescale 1ns/100ps
`default_nettype none
module eeprom_seq #(
  parameter int WRITE_CYCLES = eeprom_seq_pkg::WRITE_CYCLES,
  parameter int FIFO_DEPTH   = eeprom_seq_pkg::FIFO_DEPTH
) (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       cs_n_pin,
  input  wire logic       sck_pin,
  input  wire logic       si_pin,
  output logic            so_r,
  output logic            so_oe_n_r,
  input  wire logic [1:0] block_protect,
  output logic            busy_flag,
  output logic            write_enable_latch
);
  localparam int AB = eeprom_seq_pkg::ADDR_BITS;
  localparam int NW = (1 << AB) / eeprom_seq_pkg::WORD_BYTES;
  localparam int TW = $clog2(WRITE_CYCLES + 1);
  typedef enum {ST_OPCODE, ST_ADDR, ST_READ, ST_WDATA, ST_STATUS, ST_POLL, ST_IGNORE} state_t;
  typedef enum {WS_IDLE, WS_RMW, WS_WAIT} wstate_t;

  //--------------------------------------------------------------
  // pin synchronisers and edge detect
  //--------------------------------------------------------------
  logic [1:0] cs_s_r;
  logic [1:0] sck_s_r;
  logic [1:0] si_s_r;
  logic       sck_d_r;
  logic       cs_d_r;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cs_s_r  <= 2'h3;
      sck_s_r <= 2'h0;
      si_s_r  <= 2'h0;
      sck_d_r <= 1'b0;
      cs_d_r  <= 1'b1;
    end else begin
      cs_s_r  <= {cs_s_r[0], cs_n_pin};
      sck_s_r <= {sck_s_r[0], sck_pin};
      si_s_r  <= {si_s_r[0], si_pin};
      sck_d_r <= sck_s_r[1];
      cs_d_r  <= cs_s_r[1];
    end
  end
  wire sel      = !cs_s_r[1];
  wire sck_rise = sel && sck_s_r[1] && !sck_d_r;
  wire sck_fall = sel && !sck_s_r[1] && sck_d_r;
  wire cs_rise  = cs_s_r[1] && !cs_d_r;
  wire cs_fall  = !cs_s_r[1] && cs_d_r;

  //--------------------------------------------------------------
  // array of ecc words
  //--------------------------------------------------------------
  logic [37:0] mem [NW];

  // hamming check bits over 32 data bits, six parity positions up to 38
  function automatic logic [5:0] ecc_gen(input logic [31:0] d);
    logic [5:0] c;
    c = '0;
    for (int i = 0, p = 3; i < 32; i++, p++) begin
      while ((p & (p - 1)) == 0) p++;
      for (int k = 0; k < 6; k++) begin
        if (p[k]) c[k] = c[k] ^ d[i];
      end
    end
    return c;
  endfunction

  // correct one flipped data bit from the syndrome
  function automatic logic [31:0] ecc_fix(input logic [37:0] w);
    logic [5:0]  s;
    logic [31:0] d;
    d = w[31:0];
    s = ecc_gen(d) ^ w[37:32];
    for (int i = 0, p = 3; i < 32; i++, p++) begin
      while ((p & (p - 1)) == 0) p++;
      if (s == 6'(p)) d[i] = !d[i];
    end
    return d;
  endfunction

  //--------------------------------------------------------------
  // serial command decode
  //--------------------------------------------------------------
  state_t           st_r;
  logic [4:0]       bitcnt_r;
  logic [7:0]       sh_r;
  logic [7:0]       op_r;
  logic [AB-1:0]    addr_r;
  logic [AB-1:0]    wbase_r;
  logic [7:0]       tx_r;
  logic             write_enable_cmd_pend_r;
  logic             wvalid_r;
  logic             wel_r;
  logic             busy_r;
  wstate_t          ws_r;
  logic [TW-1:0]    tmr_r;

  wire [7:0] sh_nxt   = {sh_r[6:0], si_s_r[1]};
  wire       is_write = (sh_nxt == eeprom_seq_pkg::OP_WRITE_A) ||
                        (sh_nxt == eeprom_seq_pkg::OP_WRITE_B);
  wire [31:0] rd_word = ecc_fix(mem[addr_r[AB-1:2]]);
  wire [7:0]  rd_byte = rd_word[8*addr_r[1:0] +: 8];
  wire [7:0]  status  = {4'h0, block_protect, wel_r, busy_r};
  wire [7:0]  poll_b  = busy_r ? eeprom_seq_pkg::POLL_BUSY
                               : eeprom_seq_pkg::POLL_IDLE;

  eeprom_seq_pkg::page_byte_t fin;
  eeprom_seq_pkg::page_byte_t fout;
  logic fin_valid;
  logic fin_ready;
  logic fout_valid;
  wire  fout_ready = (ws_r == WS_RMW);
  assign fin = '{col: addr_r[7:0], data: sh_nxt};
  assign fin_valid = (st_r == ST_WDATA) && sck_rise && (bitcnt_r == 5'd7);

  // bit engine: sample on rising sck, shift out on falling sck
  always_ff @(posedge core_clk) begin
    if (!rstn || cs_s_r[1]) begin
      st_r     <= ST_OPCODE;
      bitcnt_r <= '0;
      sh_r     <= '0;
      so_r     <= 1'b0;
      so_oe_n_r <= 1'b1;
    end else if (sck_rise) begin
      sh_r     <= sh_nxt;
      bitcnt_r <= bitcnt_r + 1'b1;
      case (st_r)
        ST_OPCODE: if (bitcnt_r == 5'd7) begin
          op_r     <= sh_nxt;
          bitcnt_r <= '0;
          if (busy_r && sh_nxt != eeprom_seq_pkg::OP_STATUS &&
              sh_nxt != eeprom_seq_pkg::OP_POLL) st_r <= ST_IGNORE;
          else if (sh_nxt == eeprom_seq_pkg::OP_READ) st_r <= ST_ADDR;
          else if (is_write && wel_r) st_r <= ST_ADDR;
          else if (sh_nxt == eeprom_seq_pkg::OP_STATUS) st_r <= ST_STATUS;
          else if (sh_nxt == eeprom_seq_pkg::OP_POLL) st_r <= ST_POLL;
          else st_r <= ST_IGNORE;
        end
        ST_ADDR: if (bitcnt_r == 5'(eeprom_seq_pkg::CMD_ADDR_BITS - 1)) begin
          bitcnt_r <= '0;
          st_r     <= (op_r == eeprom_seq_pkg::OP_READ) ? ST_READ : ST_WDATA;
        end
        ST_WDATA: if (bitcnt_r == 5'd7) begin
          bitcnt_r <= '0;
        end
        ST_READ, ST_STATUS, ST_POLL: if (bitcnt_r == 5'd7) begin
          bitcnt_r <= '0;
        end
        default: bitcnt_r <= '0;
      endcase
    end else if (sck_fall) begin
      case (st_r)
        ST_READ:   so_r <= (bitcnt_r == 5'd0) ? rd_byte[7] : tx_r[7];
        ST_STATUS: so_r <= (bitcnt_r == 5'd0) ? status[7] : tx_r[7];
        ST_POLL:   so_r <= (bitcnt_r == 5'd0) ? poll_b[7] : tx_r[7];
        default:   so_r <= 1'b0;
      endcase
      so_oe_n_r <= !(st_r == ST_READ || st_r == ST_STATUS || st_r == ST_POLL);
    end
  end

  // transmit shift register loads a fresh byte every eight bits
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tx_r <= '0;
    end else if (sck_fall && bitcnt_r == 5'd0) begin
      case (st_r)
        ST_READ:   tx_r <= {rd_byte[6:0], 1'b0};
        ST_STATUS: tx_r <= {status[6:0], 1'b0};
        ST_POLL:   tx_r <= {poll_b[6:0], 1'b0};
        default:   tx_r <= '0;
      endcase
    end else if (sck_fall) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // address: shifted in, then bumped per byte
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      addr_r <= '0;
    end else if (sck_rise && st_r == ST_ADDR) begin
      addr_r <= {addr_r[AB-2:0], si_s_r[1]};
    end else if (sck_fall && st_r == ST_READ && bitcnt_r == 5'd7) begin
      addr_r <= addr_r + 1'b1;
    end else if (fin_valid && fin_ready) begin
      addr_r[7:0] <= addr_r[7:0] + 1'b1;
    end
  end

  // armed write and write enable request, acted on at deselect
  always_ff @(posedge core_clk) begin
    if (!rstn || cs_fall) begin
      wvalid_r    <= 1'b0;
      write_enable_cmd_pend_r <= 1'b0;
    end else if (sck_rise && st_r == ST_OPCODE && bitcnt_r == 5'd7) begin
      write_enable_cmd_pend_r <= (sh_nxt == eeprom_seq_pkg::OP_WRITE_ENABLE_CMD) && !busy_r;
    end else if (fin_valid) begin
      wvalid_r <= 1'b1;
      wbase_r  <= addr_r;
    end else if (sck_rise) begin
      write_enable_cmd_pend_r <= 1'b0;
    end
  end

  //--------------------------------------------------------------
  // page buffer and internal write cycle
  //--------------------------------------------------------------
  page_fifo #(
    .WIDTH ($bits(eeprom_seq_pkg::page_byte_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .in_valid  (fin_valid),
    .in_ready  (fin_ready),
    .in_data   (fin),
    .out_valid (fout_valid),
    .out_ready (fout_ready),
    .out_data  (fout),
    .flush     (cs_fall && ws_r == WS_IDLE)
  );

  wire [AB-1:0] waddr = {wbase_r[AB-1:8], fout.col};
  wire          prot  = (block_protect == 2'h3) ||
                        (block_protect == 2'h2 && waddr >= eeprom_seq_pkg::HALF_BASE) ||
                        (block_protect == 2'h1 && waddr >= eeprom_seq_pkg::QUARTER_BASE);
  wire [31:0]   old_w = ecc_fix(mem[waddr[AB-1:2]]);
  logic [31:0]  new_w;
  always_comb begin
    new_w = old_w;
    new_w[8*waddr[1:0] +: 8] = fout.data;
  end

  // read-modify-write of each unprotected buffered byte into its ecc word
  always_ff @(posedge core_clk) begin
    if (ws_r == WS_RMW && fout_valid && !prot) begin
      mem[waddr[AB-1:2]] <= {ecc_gen(new_w), new_w};
    end
  end

  // self-timed write cycle and latches
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ws_r  <= WS_IDLE;
      busy_r <= 1'b0;
      wel_r <= 1'b0;
      tmr_r <= '0;
    end else begin
      case (ws_r)
        WS_IDLE: if (cs_rise && wvalid_r && wel_r) begin
          ws_r   <= WS_RMW;
          busy_r <= 1'b1;
          tmr_r  <= TW'(WRITE_CYCLES);
        end else if (cs_rise && write_enable_cmd_pend_r) begin
          wel_r <= 1'b1;
        end
        WS_RMW: begin
          tmr_r <= tmr_r - 1'b1;
          if (!fout_valid) ws_r <= WS_WAIT;
        end
        WS_WAIT: if (tmr_r <= TW'(1)) begin
          ws_r   <= WS_IDLE;
          busy_r <= 1'b0;
          wel_r  <= 1'b0;
        end else begin
          tmr_r <= tmr_r - 1'b1;
        end
        default: ws_r <= WS_IDLE;
      endcase
    end
  end

  // status outputs straight from flip-flops
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      busy_flag          <= 1'b0;
      write_enable_latch <= 1'b0;
    end else begin
      busy_flag          <= busy_r;
      write_enable_latch <= wel_r;
    end
  end

  //--------------------------------------------------------------
  // assertions
  //--------------------------------------------------------------
  property p_busy_ignores;
    @(posedge core_clk) disable iff (!rstn)
    (st_r == ST_IGNORE) |-> so_oe_n_r;
  endproperty
  a_busy_ignores: assert property (p_busy_ignores) else $error("ignored cmd drives so");
  property p_start_on_cs;
    @(posedge core_clk) disable iff (!rstn)
    $rose(ws_r == WS_RMW) |-> $past(cs_rise);
  endproperty
  a_start_on_cs: assert property (p_start_on_cs) else $error("write began off cs rise");
  property p_wel_clear;
    @(posedge core_clk) disable iff (!rstn)
    $fell(busy_r) |-> !wel_r;
  endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("latch not cleared at write end");
  property p_busy_out;
    @(posedge core_clk) disable iff (!rstn)
    busy_r |=> busy_flag;
  endproperty
  a_busy_out: assert property (p_busy_out) else $error("busy flag not shown");
  property p_no_write_nowel;
    @(posedge core_clk) disable iff (!rstn)
    (ws_r == WS_IDLE && cs_rise && !wel_r) |=> !busy_r;
  endproperty
  a_no_write_nowel: assert property (p_no_write_nowel) else $error("write without latch");
  property p_busy_on_start;
    @(posedge core_clk) disable iff (!rstn)
    (ws_r == WS_IDLE && cs_rise && wvalid_r && wel_r) |=> busy_r ##1 busy_r;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) else $error("busy not set at start");
  property p_read_wrap;
    @(posedge core_clk) disable iff (!rstn)
    (sck_fall && st_r == ST_READ && bitcnt_r == 5'd7 && addr_r == '1) |=> addr_r == '0;
  endproperty
  a_read_wrap: assert property (p_read_wrap) else $error("read address did not wrap");
  property p_ecc_fix;
    @(posedge core_clk) disable iff (!rstn)
    (ws_r == WS_RMW && fout_valid) |->
    ecc_fix({ecc_gen({4{fout.data}}), {4{fout.data}} ^ (32'h1 << waddr[4:0])}) == {4{fout.data}};
  endproperty
  a_ecc_fix: assert property (p_ecc_fix) else $error("single bit not corrected");
  property p_page_hold;
    @(posedge core_clk) disable iff (!rstn)
    (fin_valid && fin_ready) |=> addr_r[AB-1:8] == $past(addr_r[AB-1:8]);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page bits changed");
endmodule
`default_nettype wire

// ---- test/spi_master_model.sv ----
// spi mode 0 master model driving the eeprom sequencer pins
`timescale 1ns/100ps
`default_nettype none
module spi_master_model (
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe_n
);
  logic [7:0] tx [0:11];
  logic [7:0] rx [0:11];
  int         oe_low;

  // idle: deselected, serial clock parked low between frames
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    oe_low = 0;
  end

  // one frame of n bytes, msb first; sample so at each rising sck
  task automatic frame(input int n);
    oe_low = 0;
    cs_n <= 1'b0;
    #62.5;
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        si <= tx[b][i];
        #62.5;
        sck <= 1'b1;
        // a released line reads as the inverse of its last level
        rx[b][i] = (so_oe_n === 1'b0) ? so : ~so;
        if (so_oe_n === 1'b0) oe_low++;
        #62.5;
        sck <= 1'b0;
      end
    end
    #62.5;
    // deselect in sck low time right after the last bit
    cs_n <= 1'b1;
    si <= ~si;
    #250;
  endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the serial eeprom command sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  logic       core_clk = 1'b0;
  logic       rstn = 1'b0;
  logic [1:0] block_protect = 2'h0;
  wire logic  cs_n_pin, sck_pin, si_pin, so_r, so_oe_n_r;
  wire logic  busy_flag, write_enable_latch;
  int         fail_count = 0;
  int         samples_checked = 0;
  logic [7:0] st;
  logic [7:0] wdat [0:3];

  // 125 mhz core clock
  always #4 core_clk = ~core_clk;

  eeprom_seq #(.WRITE_CYCLES(2000)) DUT (
    .core_clk(core_clk), .rstn(rstn), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
    .si_pin(si_pin), .so_r(so_r), .so_oe_n_r(so_oe_n_r), .block_protect(block_protect),
    .busy_flag(busy_flag), .write_enable_latch(write_enable_latch)
  );

  spi_master_model spi (
    .cs_n(cs_n_pin), .sck(sck_pin), .si(si_pin), .so(so_r), .so_oe_n(so_oe_n_r)
  );

  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // short command frame; byte 1 is kept as status
  task automatic cmd(input logic [7:0] op, input int n);
    spi.tx[0] = op;
    spi.tx[1] = 8'hC3;
    spi.tx[2] = 8'hC3;
    spi.frame(n);
    st = spi.rx[1];
  endtask

  // opcode, 24-bit address, then n bytes of wdat
  task automatic mem(input logic [7:0] op, input logic [23:0] a, input int n);
    spi.tx[0] = op;
    spi.tx[1] = a[23:16];
    spi.tx[2] = a[15:8];
    spi.tx[3] = a[7:0];
    for (int i = 0; i < n; i++) spi.tx[4 + i] = wdat[i];
    spi.frame(4 + n);
  endtask

  // poll status until the busy bit drops, bounded
  task automatic wait_ready();
    int k;
    k = 0;
    st = 8'h01;
    while (st[0] !== 1'b0 && k < 40) begin
      cmd(8'h05, 2);
      k++;
    end
    `CHK(st[0], 1'b0)
  endtask

  // enable, single byte write, wait for completion
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    cmd(8'h06, 1);
    wdat[0] = d;
    mem(8'h02, a, 1);
    wait_ready();
  endtask

  // main test sequence
  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge core_clk);
    `CHK({busy_flag, write_enable_latch, so_oe_n_r}, 3'b001)
    wdat[0] = 8'h5A;
    mem(8'h02, 24'h000010, 1);
    cmd(8'h05, 2);
    `CHK(st[3:0], 4'h0)
    cmd(8'h06, 1);
    cmd(8'h05, 2);
    `CHK(st[3:0], 4'h2)
    mem(8'h07, 24'hFC0010, 1);
    repeat (8) @(posedge core_clk);
    `CHK({busy_flag, write_enable_latch}, 2'b11)
    cmd(8'h05, 2);
    `CHK(st[3:0], 4'h3)
    cmd(8'h08, 3);
    `CHK({spi.rx[1], spi.rx[2]}, 16'hFFFF)
    cmd(8'h06, 1);
    mem(8'h03, 24'h000010, 1);
    `CHK(spi.oe_low, 0)
    wait_ready();
    `CHK({st[1], write_enable_latch}, 2'b00)
    cmd(8'h08, 3);
    `CHK({spi.rx[1], spi.rx[2]}, 16'h0000)
    mem(8'h03, 24'h000010, 1);
    `CHK(spi.rx[4], 8'h5A)
    `CHK(spi.oe_low, 8)
    wr(24'h000012, 8'hC3);
    mem(8'h03, 24'h000010, 3);
    `CHK({spi.rx[4], spi.rx[6]}, 16'h5AC3)
    cmd(8'h06, 1);
    wdat = '{8'h11, 8'h22, 8'h33, 8'h44};
    mem(8'h02, 24'h0000FE, 4);
    wait_ready();
    mem(8'h03, 24'h0000FE, 2);
    `CHK({spi.rx[4], spi.rx[5]}, 16'h1122)
    mem(8'h03, 24'h000000, 2);
    `CHK({spi.rx[4], spi.rx[5]}, 16'h3344)
    wr(24'h03FFFF, 8'h77);
    mem(8'h03, 24'h03FFFF, 3);
    `CHK({spi.rx[4], spi.rx[5], spi.rx[6]}, 24'h773344)
    // each protect level: base refused; address below base accepted at levels 1 and 2
    for (int k = 1; k < 4; k++) begin
      logic [23:0] a;
      a = (k == 1) ? 24'h030000 : (k == 2) ? 24'h020000 : 24'h000000;
      wr(a, 8'h50 + k[7:0]);
      @(posedge core_clk);
      block_protect <= k[1:0];
      @(posedge core_clk);
      cmd(8'h05, 2);
      `CHK(st[3:0], {k[1:0], 2'b00})
      wr(a, 8'hAA);
      mem(8'h03, a, 1);
      `CHK(spi.rx[4], 8'h50 + k[7:0])
      if (k < 3) begin
        wr(a - 24'h1, 8'h60 + k[7:0]);
        mem(8'h03, a - 24'h1, 1);
        `CHK(spi.rx[4], 8'h60 + k[7:0])
      end
      @(posedge core_clk);
      block_protect <= 2'h0;
    end
    stop_test();
  end

  // watchdog against a hang
  initial begin
    #750000;
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
